// >>> rtl/adc_port_pkg.sv
/*
  Shared constants and types for the parallel host port of an
  eight-channel converter: frame layout, register addresses, CRC setup.
  Assumes both ends and the bench compile this package first.
*/
package adc_port_pkg;
  localparam int DATA_WIDTH = 16;
  localparam int CHANNEL_COUNT = 8;
  localparam logic [6:0] ADDR_MODE_EXIT = 7'h00;
  localparam logic [6:0] ADDR_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_INTERFACE = 7'h21;
  localparam logic [6:0] ADDR_DIGITAL_ERROR = 7'h22;
  localparam int CONFIG_STATUS_BIT = 6;
  localparam int INTERFACE_CRC_BIT = 2;
  localparam int CMD_READ_BIT = 15;
  localparam int HEADER_RESET_BIT = 7;
  localparam int HEADER_DIGITAL_BIT = 6;
  localparam int HEADER_OPEN_BIT = 5;
  localparam int HEADER_OVER_BIT = 4;
  localparam int HEADER_UNDER_BIT = 3;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [2:0] FIRST_CHANNEL = 3'h0;
  localparam logic [2:0] LAST_CHANNEL = 3'h7;
  localparam int BUFFER_DEPTH = 2;

  typedef enum logic [1:0] {
    PHASE_DATA,
    PHASE_HEADER,
    PHASE_CRC,
    PHASE_DONE
  } read_phase_type;

  // One CRC step over a whole 16-bit word, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] word);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// >>> rtl/adc_port_if.sv
/*
  Pin-level carrier between the converter port and the host.
  Assumes the bench resolves the shared bus from the two enables.
*/
interface adc_port_if;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic interface_select;
  logic busy;
  logic [15:0] host_data_out;
  logic host_data_oe;
  logic [15:0] dev_data_out;
  logic dev_data_oe;
  logic [15:0] data_in;
  logic first_channel_flag;
  logic first_channel_flag_oe;

  modport device (
    input chip_select_n, read_strobe_n, write_strobe_n, interface_select, busy, data_in,
    output dev_data_out, dev_data_oe, first_channel_flag, first_channel_flag_oe
  );
  modport host (
    output chip_select_n, read_strobe_n, write_strobe_n, interface_select, host_data_out,
    output host_data_oe,
    input busy, data_in, first_channel_flag, first_channel_flag_oe
  );
endinterface

// >>> rtl/adc_port_device.sv
/*
  Converter end of the parallel port: result registers, channel sequencer,
  status header, CRC trailer and the two-frame register access.
  Assumes strobes and busy come from another domain and are synchronised here.
*/
//
// Contract
// [RULE1] Host keeps interface select low for parallel.
// [RULE2] Chip select gates the bus drivers.
// [RULE3] Each read falling edge steps channels 1 to 8.
// [RULE4] Results readable after busy falls; else previous.
// [RULE5] Tied strobes enable and advance together.
// [RULE6] First-channel flag high on channel 1 read.
// [RULE7] Busy falling edge loads output result registers.
// [RULE8] Host never reads across busy falling edge; host only blocks a command start in the cycle busy_falling is high.
// [RULE9] CRC enable appends CRC after channel 8.
// [RULE10] CRC covers every word put on bus.
// [RULE11] Status enable adds header frame per channel.
// [RULE12] Header holds reset, fault, open, over, under, index.
// [RULE13] Channel index is zero-based binary.
// [RULE14] Register mode drives only during read strobe.
// [RULE15] Read command latches address, enters register mode.
// [RULE16] Next read returns 0, address, register content.
// [RULE17] Write frame bit15 zero carries address and data.
// [RULE18] Host reads a register before writing a series.
// [RULE19] Write to address zero returns to ADC mode.
// [RULE20] Software mode needs all oversampling inputs high.
// [RULE21] CRC polynomial and seed are shared parameters.
// [RULE22] Sequencer restarts at channel 1 on reload.
module adc_port_device
  import adc_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  adc_port_if.device port,
  input wire logic [2:0] oversampling_select,
  input wire logic [15:0] result_data [CHANNEL_COUNT],
  input wire logic [7:0] channel_diag [CHANNEL_COUNT],
  input wire logic result_valid,
  output logic result_ready,
  output logic register_mode,
  output logic [7:0] config_reg,
  output logic [7:0] interface_reg
);
  // Synchroniser stages for the pins; the second stage and its one-cycle-old copy are read.
  logic [4:0] sync_a, sync_b, sync_prev;
  logic [2:0] mode_a, mode_b;
  logic [15:0] data_a, data_b;
  logic cs_n, rd_n, wr_n, busy_s, sel_s;
  logic cs_fall, cs_rise, rd_fall, wr_rise, busy_fall;

  // Two-entry buffer between the converter and the result registers.
  logic [16*CHANNEL_COUNT-1:0] buf_mem [BUFFER_DEPTH];
  logic [8*CHANNEL_COUNT-1:0] diag_mem [BUFFER_DEPTH];
  logic buf_wr_ptr, buf_rd_ptr;
  logic [1:0] buf_count;
  logic [16*CHANNEL_COUNT-1:0] packed_res;
  logic [8*CHANNEL_COUNT-1:0] packed_diag;

  logic [15:0] results [CHANNEL_COUNT];
  logic [7:0] diags [CHANNEL_COUNT];
  logic [2:0] channel, next_channel;
  read_phase_type phase, next_phase;
  logic [15:0] crc, next_crc, out_word, next_out_word;
  logic out_oe, next_out_oe, flag, next_flag, flag_oe, next_flag_oe;
  logic reg_mode, next_reg_mode, reset_seen, next_reset_seen, soft_mode;
  logic [6:0] reg_addr, next_reg_addr;
  logic [7:0] cfg, next_cfg, intf, next_intf, header, reg_value;

  assign cs_n = sync_b[0];
  assign rd_n = sync_b[1];
  assign wr_n = sync_b[2];
  assign busy_s = sync_b[3];
  assign sel_s = sync_b[4];
  assign cs_fall = sync_prev[0] & ~cs_n;
  assign cs_rise = ~sync_prev[0] & cs_n;
  assign rd_fall = sync_prev[1] & ~rd_n;
  assign wr_rise = ~sync_prev[2] & wr_n;
  assign busy_fall = sync_prev[3] & ~busy_s;
  assign soft_mode = &mode_b; // RULE20
  assign result_ready = (buf_count != 2'(BUFFER_DEPTH));

  // Pack the converter words so the buffer entry is one vector.
  genvar g;
  generate
    for (g = 0; g < CHANNEL_COUNT; g++) begin : g_pack
      assign packed_res[16*g +: 16] = result_data[g];
      assign packed_diag[8*g +: 8] = channel_diag[g];
    end
  endgenerate

  // Header for the channel currently being read.
  always_comb begin
    header = diags[channel];
    header[HEADER_RESET_BIT] = reset_seen; // RULE12
    header[HEADER_DIGITAL_BIT] = diags[channel][HEADER_DIGITAL_BIT];
    header[2:0] = channel; // RULE13
  end

  // Register read mux over the registers this port owns.
  always_comb begin
    case (reg_addr)
      ADDR_CONFIG: reg_value = cfg;
      ADDR_INTERFACE: reg_value = intf;
      ADDR_DIGITAL_ERROR: reg_value = {7'h00, reset_seen};
      default: reg_value = REG_RESET_VALUE;
    endcase
  end

  // Next-state logic of sequencer, register access and drivers.
  always_comb begin
    next_channel = channel;
    next_phase = phase;
    next_crc = crc;
    next_out_word = out_word;
    next_out_oe = out_oe;
    next_flag = flag;
    next_flag_oe = flag_oe;
    next_reg_mode = reg_mode;
    next_reg_addr = reg_addr;
    next_cfg = cfg;
    next_intf = intf;
    next_reset_seen = reset_seen;
    if (cs_fall) begin
      next_flag_oe = 1'b1; // RULE6
      next_out_oe = ~reg_mode; // RULE2
    end
    if (rd_fall && !cs_n && !reg_mode) begin
      next_out_oe = 1'b1; // RULE5
      next_flag = (phase == PHASE_DATA) && (channel == FIRST_CHANNEL); // RULE6
      case (phase)
        PHASE_DATA: begin
          next_out_word = results[channel]; // RULE3
          next_crc = crc_step(crc, results[channel]); // RULE10
          if (soft_mode && cfg[CONFIG_STATUS_BIT]) begin
            next_phase = PHASE_HEADER; // RULE11
          end else if (channel != LAST_CHANNEL) begin
            next_channel = channel + 3'h1;
          end else begin
            next_phase = (soft_mode && intf[INTERFACE_CRC_BIT]) ? PHASE_CRC : PHASE_DONE;
          end
        end
        PHASE_HEADER: begin
          next_out_word = {header, 8'h00}; // RULE11
          next_crc = crc_step(crc, {header, 8'h00}); // RULE10
          next_reset_seen = 1'b0;
          if (channel != LAST_CHANNEL) begin
            next_channel = channel + 3'h1;
            next_phase = PHASE_DATA;
          end else begin
            next_phase = (soft_mode && intf[INTERFACE_CRC_BIT]) ? PHASE_CRC : PHASE_DONE;
          end
        end
        PHASE_CRC: begin
          next_out_word = crc; // RULE9
          next_phase = PHASE_DONE;
        end
        default: begin
          next_out_word = 16'h0000;
        end
      endcase
    end
    if (rd_fall && !cs_n && reg_mode) begin
      next_out_oe = 1'b1; // RULE14
      next_out_word = {1'b0, reg_addr, reg_value}; // RULE16
    end
    if (wr_rise && !cs_n && soft_mode && !sel_s) begin
      if (data_b[CMD_READ_BIT]) begin
        next_reg_addr = data_b[14:8]; // RULE15
        next_reg_mode = 1'b1;
      end else begin
        case (data_b[14:8]) // RULE17
          ADDR_CONFIG: next_cfg = data_b[7:0];
          ADDR_INTERFACE: next_intf = data_b[7:0];
          default: next_cfg = cfg;
        endcase
        if (data_b[14:8] == ADDR_MODE_EXIT) begin
          next_reg_mode = 1'b0; // RULE19
        end
      end
    end
    if (reg_mode && (rd_n || cs_n)) begin
      next_out_oe = 1'b0; // RULE14
    end
    if (busy_fall) begin
      next_channel = FIRST_CHANNEL; // RULE22
      next_phase = PHASE_DATA;
      next_crc = CRC_SEED; // RULE21
    end
    if (cs_rise || cs_n) begin
      next_out_oe = 1'b0; // RULE2
      next_flag_oe = 1'b0;
    end
  end

  // Pin synchronisers and edge history.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_a <= 5'h07; // Busy and select idle low, so no false edge follows reset.
      sync_b <= 5'h07;
      sync_prev <= 5'h07;
      mode_a <= 3'h0;
      mode_b <= 3'h0;
      data_a <= 16'h0000;
      data_b <= 16'h0000;
    end else if (clk_en) begin
      sync_a <= {port.interface_select, port.busy, port.write_strobe_n, port.read_strobe_n,
                 port.chip_select_n};
      sync_b <= sync_a;
      sync_prev <= sync_b;
      mode_a <= oversampling_select;
      mode_b <= mode_a;
      data_a <= port.data_in;
      data_b <= data_a;
    end
  end

  // Buffer and result registers; busy falling edge pops a fresh set when one is buffered.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
      buf_count <= 2'h0;
      for (int i = 0; i < CHANNEL_COUNT; i++) begin
        results[i] <= 16'h0000;
        diags[i] <= 8'h00;
      end
    end else if (clk_en) begin
      if (result_valid && result_ready) begin
        buf_mem[buf_wr_ptr] <= packed_res;
        diag_mem[buf_wr_ptr] <= packed_diag;
        buf_wr_ptr <= ~buf_wr_ptr;
      end
      if (busy_fall && buf_count != 2'h0) begin // RULE4
        for (int i = 0; i < CHANNEL_COUNT; i++) begin
          results[i] <= buf_mem[buf_rd_ptr][16*i +: 16]; // RULE7
          diags[i] <= diag_mem[buf_rd_ptr][8*i +: 8];
        end
        buf_rd_ptr <= ~buf_rd_ptr;
      end
      buf_count <= buf_count + 2'(result_valid && result_ready)
                   - 2'(busy_fall && buf_count != 2'h0);
    end
  end

  // Sequencer, register and driver state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      channel <= FIRST_CHANNEL;
      phase <= PHASE_DATA;
      crc <= CRC_SEED;
      out_word <= 16'h0000;
      out_oe <= 1'b0;
      flag <= 1'b0;
      flag_oe <= 1'b0;
      reg_mode <= 1'b0;
      reg_addr <= 7'h00;
      cfg <= REG_RESET_VALUE;
      intf <= REG_RESET_VALUE;
      reset_seen <= 1'b1;
    end else if (clk_en) begin
      channel <= next_channel;
      phase <= next_phase;
      crc <= next_crc;
      out_word <= next_out_word;
      out_oe <= next_out_oe;
      flag <= next_flag;
      flag_oe <= next_flag_oe;
      reg_mode <= next_reg_mode;
      reg_addr <= next_reg_addr;
      cfg <= next_cfg;
      intf <= next_intf;
      reset_seen <= next_reset_seen;
    end
  end

  assign port.dev_data_out = out_word;
  assign port.dev_data_oe = out_oe;
  assign port.first_channel_flag = flag;
  assign port.first_channel_flag_oe = flag_oe;
  assign register_mode = reg_mode;
  assign config_reg = cfg;
  assign interface_reg = intf;
endmodule

// >>> rtl/adc_port_host.sv
/*
  Host end of the parallel port: runs one command at a time as a strobe
  sequence and returns each word read with a one-cycle valid pulse.
  Assumes the device answers within the strobe low time.
*/
module adc_port_host
  import adc_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  adc_port_if.host port,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_word,
  output logic cmd_ready,
  output logic [15:0] rsp_word,
  output logic rsp_valid,
  output logic first_flag_seen,
  output logic busy_level
);
  localparam logic [3:0] STROBE_CYCLES = 4'h8;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_LOW,
    HOST_HIGH
  } host_state_type;

  host_state_type state;
  host_state_type next_state;
  logic [3:0] count;
  logic [3:0] next_count;
  logic is_write;
  logic next_is_write;
  logic [15:0] word;
  logic [15:0] next_word;
  logic [15:0] rsp;
  logic [15:0] next_rsp;
  logic rvalid;
  logic next_rvalid;
  logic flag_seen;
  logic next_flag_seen;
  logic [2:0] busy_sync;
  logic busy_falling;

  // Strobe sequencer; interface select stays low throughout.
  always_comb begin
    next_state = state;
    next_count = count;
    next_is_write = is_write;
    next_word = word;
    next_rsp = rsp;
    next_rvalid = 1'b0;
    next_flag_seen = flag_seen;
    case (state)
      HOST_IDLE: begin
        if (cmd_valid && !busy_falling) begin // RULE8
          next_state = HOST_LOW;
          next_is_write = cmd_write;
          next_word = cmd_word;
          next_count = 4'h0;
        end
      end
      HOST_LOW: begin
        next_count = count + 4'h1;
        if (count == STROBE_CYCLES) begin
          if (!is_write) begin
            next_rsp = port.data_in;
            next_rvalid = 1'b1;
            next_flag_seen = port.first_channel_flag;
          end
          next_state = HOST_HIGH;
          next_count = 4'h0;
        end
      end
      HOST_HIGH: begin
        next_count = count + 4'h1;
        if (count == STROBE_CYCLES) begin
          next_state = HOST_IDLE;
        end
      end
      default: next_state = HOST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= HOST_IDLE;
      count <= 4'h0;
      is_write <= 1'b0;
      word <= 16'h0000;
      rsp <= 16'h0000;
      rvalid <= 1'b0;
      flag_seen <= 1'b0;
      busy_sync <= 3'h0;
    end else if (clk_en) begin
      state <= next_state;
      count <= next_count;
      is_write <= next_is_write;
      word <= next_word;
      rsp <= next_rsp;
      rvalid <= next_rvalid;
      flag_seen <= next_flag_seen;
      busy_sync <= {busy_sync[1:0], port.busy};
    end
  end

  assign port.interface_select = 1'b0; // RULE1
  assign port.chip_select_n = (state == HOST_IDLE);
  assign port.read_strobe_n = !(state == HOST_LOW && !is_write);
  assign port.write_strobe_n = !(state == HOST_LOW && is_write); // RULE15 RULE17
  assign port.host_data_out = word;
  assign port.host_data_oe = (state != HOST_IDLE) && is_write;
  // Reads may run while busy is high; only a busy fall in flight holds a command off.
  assign busy_falling = busy_sync[2] & ~busy_sync[1];
  assign cmd_ready = (state == HOST_IDLE) && !busy_falling; // RULE8
  assign rsp_word = rsp;
  assign rsp_valid = rvalid;
  assign first_flag_seen = flag_seen;
  assign busy_level = busy_sync[1];
endmodule

// >>> bench/adc_port_properties.sv
/*
  Timing checks on the parallel port wires between the two ends.
  Assumes the bench instantiates it beside the interface instance.
*/
module adc_port_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_data_oe,
  input wire logic [15:0] dev_data_out,
  input wire logic dev_data_oe,
  input wire logic first_channel_flag,
  input wire logic first_channel_flag_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Windows long enough to pass the device's input synchronisers.
  sequence deselected;
    chip_select_n [*5];
  endsequence
  sequence read_window;
    (!chip_select_n && !read_strobe_n) [*6];
  endsequence

  // Drivers follow chip select and the read strobe.
  a_bus_release: assert property ($rose(chip_select_n) |-> ##[1:5] !dev_data_oe)
    else $error("data bus still driven after deselect");
  a_flag_float: assert property (deselected |-> !first_channel_flag_oe)
    else $error("first channel flag driven while deselected");
  a_select_drives: assert property (read_window |-> dev_data_oe && first_channel_flag_oe)
    else $error("outputs not driven during a read");
  // The flag rises only inside a read and drops on the following read.
  a_flag_rise: assert property ($rose(first_channel_flag) |-> !read_strobe_n && !chip_select_n)
    else $error("first channel flag rose outside a read");
  a_flag_drop: assert property (first_channel_flag && $fell(read_strobe_n) |-> ##[1:5] !first_channel_flag)
    else $error("first channel flag held past the next read");
  // Output words move only on a read, and the host frames writes cleanly.
  a_data_step: assert property ($changed(dev_data_out) |-> !read_strobe_n)
    else $error("output word changed without a read");
  a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes low together");
  a_write_hold: assert property ($rose(write_strobe_n) |-> $past(host_data_oe))
    else $error("host data released before write strobe rose");
endmodule

// >>> bench/tb.sv
/*
  Testbench joining host end and device end over the parallel port.
  Assumes the package is compiled first; the bench plays the converter core.
*/
module tb import adc_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, cmd_valid, cmd_write, cmd_ready, rsp_valid, first_flag_seen;
  logic result_valid, result_ready, register_mode, f, busy_level;
  logic [15:0] cmd_word, rsp_word, w, crc;
  logic [15:0] float_bus = 16'h5A5A;
  logic [15:0] result_data [CHANNEL_COUNT];
  logic [7:0] channel_diag [CHANNEL_COUNT];
  logic [7:0] config_reg, interface_reg, hdr;
  logic [2:0] oversampling_select;
  int mismatches, num_checks;
  adc_port_if bus ();

  // Released bus shows a pattern that flips every cycle.
  assign bus.data_in = bus.host_data_oe ? bus.host_data_out :
                       bus.dev_data_oe ? bus.dev_data_out : float_bus;
  always @(posedge core_clk) float_bus <= ~float_bus;

  // Clock of 50 ns period.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  adc_port_device i_adc_port_device (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .port(bus.device), .oversampling_select(oversampling_select), .result_data(result_data),
    .channel_diag(channel_diag), .result_valid(result_valid), .result_ready(result_ready),
    .register_mode(register_mode), .config_reg(config_reg), .interface_reg(interface_reg));
  adc_port_host i_adc_port_host (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .port(bus.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .rsp_word(rsp_word), .rsp_valid(rsp_valid),
    .first_flag_seen(first_flag_seen), .busy_level(busy_level));
  adc_port_properties i_adc_port_properties (.core_clk(core_clk), .reset(reset),
    .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .host_data_oe(bus.host_data_oe),
    .dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe),
    .first_channel_flag(bus.first_channel_flag),
    .first_channel_flag_oe(bus.first_channel_flag_oe));

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Hands one frame to the host; a read waits for its word, a write for readiness.
  task automatic frame(input logic wr, input logic [15:0] word, output logic [15:0] got,
                       output logic flag);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_word = word;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++n < 200);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    do @(posedge core_clk); while ((wr ? cmd_ready : rsp_valid) !== 1'b1 && ++n < 200);
    got = rsp_word;
    flag = first_flag_seen;
    if (n >= 200) mismatches++;
  endtask

  // Register access as command frame, then read frame for reads.
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    frame(1'b1, {1'b0, a, d}, w, f);
  endtask
  task automatic reg_read(input logic [6:0] a, input logic [7:0] d);
    frame(1'b1, {1'b1, a, 8'h00}, w, f);
    frame(1'b0, 16'h0000, w, f);
    check("register read", {1'b0, a, d}, w);
  endtask

  function automatic logic [15:0] sample(input logic [3:0] s, input int c);
    return {s, 4'hC, 5'h00, 3'(c)};
  endfunction
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction

  // Offers one result set to the device buffer.
  task automatic push(input logic [3:0] s);
    int n;
    n = 0;
    @(negedge core_clk);
    for (int c = 0; c < CHANNEL_COUNT; c++) result_data[c] = sample(s, c);
    result_valid = 1'b1;
    do @(posedge core_clk); while (result_ready !== 1'b1 && ++n < 200);
    @(negedge core_clk);
    result_valid = 1'b0;
  endtask

  // Moves busy and lets the synchronisers settle.
  task automatic set_busy(input logic b);
    @(negedge core_clk);
    bus.busy = b;
    repeat (6) @(posedge core_clk);
  endtask

  // Reads eight channels and checks words and first-channel flag.
  task automatic read_set(input logic [3:0] s);
    for (int c = 0; c < CHANNEL_COUNT; c++) begin
      frame(1'b0, 16'h0000, w, f);
      check("channel word", sample(s, c), w);
      check("first flag", {15'h0000, c == 0}, {15'h0000, f});
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    {cmd_valid, cmd_write, result_valid, bus.busy} = 4'h0;
    cmd_word = 16'h0000;
    oversampling_select = 3'h0;
    for (int c = 0; c < CHANNEL_COUNT; c++) result_data[c] = 16'h0000;
    for (int c = 0; c < CHANNEL_COUNT; c++) channel_diag[c] = (c % 2) ? 8'hFF : 8'h00;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    push(4'h1);
    set_busy(1'b1);
    check("busy level", 16'h0001, {15'h0000, busy_level});
    set_busy(1'b0);
    read_set(4'h1);
    set_busy(1'b1);
    set_busy(1'b0);
    push(4'h2);
    push(4'h3);
    @(negedge core_clk);
    result_valid = 1'b1;
    repeat (3) @(posedge core_clk);
    check("buffer full", 16'h0000, {15'h0000, result_ready});
    @(negedge core_clk);
    result_valid = 1'b0;
    set_busy(1'b1);
    read_set(4'h1);
    set_busy(1'b0);
    read_set(4'h2);
    set_busy(1'b1);
    set_busy(1'b0);
    read_set(4'h3);
    $display("Test conversion reads done");
    reg_write(ADDR_CONFIG, 8'h40);
    check("hardware mode write", 16'h0000, {8'h00, config_reg});
    @(negedge core_clk);
    oversampling_select = 3'h7;
    reg_read(ADDR_CONFIG, REG_RESET_VALUE);
    check("register mode", 16'h0001, {15'h0000, register_mode});
    reg_write(ADDR_CONFIG, 8'h40);
    check("config", 16'h0040, {8'h00, config_reg});
    reg_write(ADDR_INTERFACE, 8'h04);
    check("interface", 16'h0004, {8'h00, interface_reg});
    reg_read(ADDR_INTERFACE, 8'h04);
    reg_write(ADDR_MODE_EXIT, 8'h00);
    check("register mode exit", 16'h0000, {15'h0000, register_mode});
    $display("Test register access done");
    push(4'h4);
    set_busy(1'b1);
    set_busy(1'b0);
    crc = CRC_SEED;
    for (int c = 0; c < CHANNEL_COUNT; c++) begin
      frame(1'b0, 16'h0000, w, f);
      check("status data", sample(4'h4, c), w);
      crc = fold(crc, sample(4'h4, c));
      hdr = (channel_diag[c] & 8'h78) | 8'(c) | ((c == 0) ? 8'h80 : 8'h00);
      frame(1'b0, 16'h0000, w, f);
      check("status header", {hdr, 8'h00}, w);
      crc = fold(crc, {hdr, 8'h00});
    end
    frame(1'b0, 16'h0000, w, f);
    check("crc trailer", crc, w);
    $display("Test status and crc done");
    wrap_up();
  end
endmodule
